// ===== src/dps_defines.svh
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define DPS_CLK_KHZ 20000
`define DPS_TICK_MS 100
`define DPS_TICKS_PER_SEC 4'h9
`define DPS_SECS_PER_MIN 6'h3b
// ----------------------------------------
// register indices (word address)
// ----------------------------------------
`define DPS_NCFG 18
`define DPS_CTRL 5'h00
`define DPS_ROT_TIME 5'h01
`define DPS_INTERLOCK 5'h02
`define DPS_HS_DWELL 5'h03
`define DPS_LS_DWELL 5'h04
`define DPS_SLEEP_LVL 5'h05
`define DPS_SLEEP_DWELL 5'h06
`define DPS_WAKE_LVL 5'h07
`define DPS_SLEEP_FREQ 5'h08
`define DPS_SLEEP_FDWELL 5'h09
`define DPS_ACC_STALL 5'h0a
`define DPS_CS_STALL 5'h0b
`define DPS_DEC_STALL 5'h0c
`define DPS_OT_LEVEL 5'h0d
`define DPS_OT_TIME 5'h0e
`define DPS_HS_FREQ 5'h0f
`define DPS_LS_FREQ 5'h10
`define DPS_OV_LEVEL 5'h11
`define DPS_STATUS 5'h12
`define DPS_IRQ_STAT 5'h13
`define DPS_IRQ_MASK 5'h14
`define DPS_FAULT_CLR 5'h15
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define DPS_CTRL_RESUME 0
`define DPS_CTRL_PUMPS_LO 1
`define DPS_CTRL_OVSTALL 3
`define DPS_CTRL_OTMODE_LO 4
`define DPS_CTRL_RST 16'h0008
`define DPS_ROT_RST 16'h003c
`define DPS_INTERLOCK_RST 16'h0032
`define DPS_HS_DWELL_RST 16'h003c
`define DPS_LS_DWELL_RST 16'h003c
`define DPS_SLEEP_LVL_RST 16'h005f
`define DPS_SLEEP_DWELL_RST 16'h001e
`define DPS_WAKE_LVL_RST 16'h0050
`define DPS_SLEEP_FREQ_RST 16'h07d0
`define DPS_SLEEP_FDWELL_RST 16'h0014
`define DPS_ACC_STALL_RST 16'h0096
`define DPS_OT_TIME_RST 16'h0064
`define DPS_HS_FREQ_RST 16'h1388
`define DPS_LS_FREQ_RST 16'h03e8
`define DPS_OV_LEVEL_RST 16'h0320
`endif

// ===== src/dps_pkg.sv
package dps_pkg;
  // live measurements from the converter logic, same clock
  typedef struct packed {
    logic [7:0] current;
    logic [15:0] dc_volt;
    logic [15:0] freq;
    logic [7:0] feedback;
  } dps_meas_t;
  // ramp generator state, same clock
  typedef struct packed {
    logic running;
    logic accel;
    logic decel;
    logic at_speed;
  } dps_run_t;
  typedef enum logic [1:0] {SL_RUN, SL_ENTRY, SL_SLEEP} dps_sleep_t;
  typedef enum logic {PS_RUN, PS_GAP} dps_pump_t;
endpackage : dps_pkg

// ===== src/dps_supervisor.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_supervisor
  import dps_pkg::*;
#(
  parameter int TICK_CYCLES = `DPS_TICK_MS * `DPS_CLK_KHZ
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire dps_meas_t meas,
  input wire dps_run_t run,
  input wire logic [3:0] prog_step,
  output logic [3:0] resume_step,
  output logic resume_valid,
  output logic hold_accel,
  output logic hold_decel,
  output logic lower_freq,
  output logic [1:0] pump_on,
  output logic sleep_freq_req,
  output logic sleep_stop,
  output logic ot_alarm,
  output logic fault_trip,
  output logic irq
);
  // ----------------------------------------
  // reset release and helpers
  // ----------------------------------------
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic rst_n_i = rst_s2_ff;

  // a level of zero switches the comparison off
  function automatic logic above(input logic [15:0] val, input logic [15:0] lvl);
    above = (lvl != 16'h0000) && (val > lvl);
  endfunction : above

  function automatic logic [15:0] cfg_rst(input int idx);
    case (idx)
      0: cfg_rst = `DPS_CTRL_RST;
      1: cfg_rst = `DPS_ROT_RST;
      2: cfg_rst = `DPS_INTERLOCK_RST;
      3: cfg_rst = `DPS_HS_DWELL_RST;
      4: cfg_rst = `DPS_LS_DWELL_RST;
      5: cfg_rst = `DPS_SLEEP_LVL_RST;
      6: cfg_rst = `DPS_SLEEP_DWELL_RST;
      7: cfg_rst = `DPS_WAKE_LVL_RST;
      8: cfg_rst = `DPS_SLEEP_FREQ_RST;
      9: cfg_rst = `DPS_SLEEP_FDWELL_RST;
      10: cfg_rst = `DPS_ACC_STALL_RST;
      14: cfg_rst = `DPS_OT_TIME_RST;
      15: cfg_rst = `DPS_HS_FREQ_RST;
      16: cfg_rst = `DPS_LS_FREQ_RST;
      17: cfg_rst = `DPS_OV_LEVEL_RST;
      default: cfg_rst = 16'h0000;
    endcase
  endfunction : cfg_rst

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0] cfg_ff [`DPS_NCFG];
  generate
    for (genvar gi = 0; gi < `DPS_NCFG; gi++)
    begin : g_cfg
      always_ff @(posedge clk or negedge rst_n_i)
      begin
        if (!rst_n_i)
          cfg_ff[gi] <= cfg_rst(gi);
        else if (reg_wr && reg_addr == 5'(gi))
          cfg_ff[gi] <= reg_wdata;
      end
    end
  endgenerate

  wire logic [15:0] ctrl = cfg_ff[`DPS_CTRL];
  wire logic resume_en = ctrl[`DPS_CTRL_RESUME];
  wire logic [1:0] pump_cnt = ctrl[`DPS_CTRL_PUMPS_LO +: 2];
  wire logic ov_en = ctrl[`DPS_CTRL_OVSTALL];
  wire logic [1:0] ot_mode = ctrl[`DPS_CTRL_OTMODE_LO +: 2];

  // ----------------------------------------
  // time base: 0.1 s ticks and seconds
  // ----------------------------------------
  logic [23:0] div_ff;
  logic [3:0] tenth_ff;
  logic tick_ff, sec_tick_ff;
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_ff <= 24'h00_0000;
      tenth_ff <= 4'h0;
      tick_ff <= 1'b0;
      sec_tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == 24'(TICK_CYCLES - 1));
      div_ff <= (div_ff == 24'(TICK_CYCLES - 1)) ? 24'h00_0000 : div_ff + 24'h00_0001;
      sec_tick_ff <= tick_ff && tenth_ff == `DPS_TICKS_PER_SEC;
      if (tick_ff)
        tenth_ff <= (tenth_ff == `DPS_TICKS_PER_SEC) ? 4'h0 : tenth_ff + 4'h1;
    end
  end

  // ----------------------------------------
  // stall prevention
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_accel <= 1'b0;
      hold_decel <= 1'b0;
      lower_freq <= 1'b0;
    end
    else
    begin
      hold_accel <= run.accel && above(16'(meas.current), cfg_ff[`DPS_ACC_STALL]);
      hold_decel <= run.decel && ((ov_en && meas.dc_volt > cfg_ff[`DPS_OV_LEVEL])
        || above(16'(meas.current), cfg_ff[`DPS_DEC_STALL]));
      lower_freq <= run.at_speed && above(16'(meas.current), cfg_ff[`DPS_CS_STALL]);
    end
  end

  // ----------------------------------------
  // over-torque
  // ----------------------------------------
  // modes 0/1 watch only at set frequency, 2/3 whenever the motor runs
  wire logic ot_win = run.running && (ot_mode[1] || run.at_speed);
  wire logic ot_over = ot_win && above(16'(meas.current), cfg_ff[`DPS_OT_LEVEL]);
  logic [15:0] ot_cnt_ff;
  wire logic fault_clr = reg_wr && reg_addr == `DPS_FAULT_CLR && reg_wdata[0];
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ot_cnt_ff <= 16'h0000;
    else if (!ot_over && !fault_trip)
      ot_cnt_ff <= 16'h0000;
    else if (ot_over && tick_ff && ot_cnt_ff != 16'hffff)
      ot_cnt_ff <= ot_cnt_ff + 16'h0001;
  end

  // trip latches until software clears it; modes 0/2 only raise the alarm
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ot_alarm <= 1'b0;
      fault_trip <= 1'b0;
    end
    else
    begin
      ot_alarm <= ot_over && ({ot_cnt_ff, 1'b0} > {1'b0, cfg_ff[`DPS_OT_TIME]});
      if (ot_over && ot_mode[0] && ot_cnt_ff > cfg_ff[`DPS_OT_TIME])
        fault_trip <= 1'b1;
      else if (fault_clr)
        fault_trip <= 1'b0;
    end
  end

  // ----------------------------------------
  // program resume memory
  // ----------------------------------------
  logic run_d_ff, trip_d_ff;
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_d_ff <= 1'b0;
      trip_d_ff <= 1'b0;
      resume_step <= 4'h0;
      resume_valid <= 1'b0;
    end
    else
    begin
      run_d_ff <= run.running;
      trip_d_ff <= fault_trip;
      if (!resume_en)
        resume_valid <= 1'b0;
      else if ((run_d_ff && !run.running) || (fault_trip && !trip_d_ff))
      begin
        resume_step <= prog_step;
        resume_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // auxiliary pump staging
  // ----------------------------------------
  logic [7:0] hs_cnt_ff, ls_cnt_ff;
  wire logic hs_zone = run.running && meas.freq >= cfg_ff[`DPS_HS_FREQ];
  wire logic ls_zone = run.running && meas.freq <= cfg_ff[`DPS_LS_FREQ];
  wire logic hs_done = 16'(hs_cnt_ff) >= cfg_ff[`DPS_HS_DWELL];
  wire logic ls_done = 16'(ls_cnt_ff) >= cfg_ff[`DPS_LS_DWELL];
  // dwell counters restart once they act so the next pump needs a fresh dwell
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_cnt_ff <= 8'h00;
      ls_cnt_ff <= 8'h00;
    end
    else
    begin
      if (!hs_zone || hs_done)
        hs_cnt_ff <= 8'h00;
      else if (sec_tick_ff)
        hs_cnt_ff <= hs_cnt_ff + 8'h01;
      if (!ls_zone || ls_done)
        ls_cnt_ff <= 8'h00;
      else if (sec_tick_ff)
        ls_cnt_ff <= ls_cnt_ff + 8'h01;
    end
  end

  dps_pump_t pst_ff, nxt_pst;
  logic [1:0] n_on_ff, nxt_n_on;
  logic lead_ff, nxt_lead;
  logic [15:0] rot_ff, nxt_rot;
  logic [15:0] gap_ff, nxt_gap;
  logic [5:0] rot_sec_ff, nxt_rot_sec;
  always_comb
  begin
    nxt_pst = pst_ff;
    nxt_n_on = n_on_ff;
    nxt_lead = lead_ff;
    nxt_rot = rot_ff;
    nxt_rot_sec = rot_sec_ff;
    nxt_gap = gap_ff;
    case (pst_ff)
      PS_RUN:
      begin
        if (n_on_ff > pump_cnt)
          nxt_n_on = pump_cnt;
        else if (hs_done && n_on_ff < pump_cnt)
          nxt_n_on = n_on_ff + 2'd1;
        else if (ls_done && n_on_ff != 2'd0)
          nxt_n_on = n_on_ff - 2'd1;
        // minutes count from when this pump took duty, not from a free-running clock
        if (pump_cnt == 2'd2 && n_on_ff == 2'd1)
        begin
          if (sec_tick_ff)
            nxt_rot_sec = (rot_sec_ff == `DPS_SECS_PER_MIN) ? 6'h00 : rot_sec_ff + 6'h01;
          if (sec_tick_ff && rot_sec_ff == `DPS_SECS_PER_MIN)
            nxt_rot = rot_ff + 16'h0001;
          if (rot_ff >= cfg_ff[`DPS_ROT_TIME])
          begin
            nxt_rot = 16'h0000;
            nxt_rot_sec = 6'h00;
            nxt_lead = !lead_ff;
            nxt_gap = 16'h0000;
            nxt_pst = PS_GAP;
          end
        end
        else
        begin
          nxt_rot = 16'h0000;
          nxt_rot_sec = 6'h00;
        end
      end
      PS_GAP:
      begin
        if (tick_ff)
          nxt_gap = gap_ff + 16'h0001;
        if (gap_ff >= cfg_ff[`DPS_INTERLOCK])
          nxt_pst = PS_RUN;
      end
      default: nxt_pst = PS_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pst_ff <= PS_RUN;
      n_on_ff <= 2'd0;
      lead_ff <= 1'b0;
      rot_ff <= 16'h0000;
      rot_sec_ff <= 6'h00;
      gap_ff <= 16'h0000;
      pump_on <= 2'b00;
    end
    else
    begin
      pst_ff <= nxt_pst;
      n_on_ff <= nxt_n_on;
      lead_ff <= nxt_lead;
      rot_ff <= nxt_rot;
      rot_sec_ff <= nxt_rot_sec;
      gap_ff <= nxt_gap;
      // both contacts open through the interlock gap
      if (nxt_pst == PS_GAP)
        pump_on <= 2'b00;
      else if (nxt_n_on == 2'd2)
        pump_on <= 2'b11;
      else if (nxt_n_on == 2'd1)
        pump_on <= nxt_lead ? 2'b10 : 2'b01;
      else
        pump_on <= 2'b00;
    end
  end

  // ----------------------------------------
  // sleep and wakeup
  // ----------------------------------------
  dps_sleep_t sl_ff, nxt_sl;
  logic [7:0] sl_cnt_ff, nxt_sl_cnt;
  always_comb
  begin
    nxt_sl = sl_ff;
    nxt_sl_cnt = sl_cnt_ff;
    case (sl_ff)
      SL_RUN:
      begin
        if (!run.running || 16'(meas.feedback) < cfg_ff[`DPS_SLEEP_LVL])
          nxt_sl_cnt = 8'h00;
        else if (sec_tick_ff)
          nxt_sl_cnt = sl_cnt_ff + 8'h01;
        if (16'(sl_cnt_ff) >= cfg_ff[`DPS_SLEEP_DWELL])
        begin
          nxt_sl = SL_ENTRY;
          nxt_sl_cnt = 8'h00;
        end
      end
      SL_ENTRY:
      begin
        if (sec_tick_ff)
          nxt_sl_cnt = sl_cnt_ff + 8'h01;
        if (16'(meas.feedback) < cfg_ff[`DPS_WAKE_LVL])
          nxt_sl = SL_RUN;
        else if (16'(sl_cnt_ff) >= cfg_ff[`DPS_SLEEP_FDWELL])
          nxt_sl = SL_SLEEP;
      end
      SL_SLEEP:
      begin
        if (16'(meas.feedback) < cfg_ff[`DPS_WAKE_LVL])
          nxt_sl = SL_RUN;
      end
      default: nxt_sl = SL_RUN;
    endcase
    if (nxt_sl != sl_ff && nxt_sl != SL_ENTRY)
      nxt_sl_cnt = 8'h00;
  end

  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sl_ff <= SL_RUN;
      sl_cnt_ff <= 8'h00;
      sleep_freq_req <= 1'b0;
      sleep_stop <= 1'b0;
    end
    else
    begin
      sl_ff <= nxt_sl;
      sl_cnt_ff <= nxt_sl_cnt;
      sleep_freq_req <= nxt_sl == SL_ENTRY;
      sleep_stop <= nxt_sl == SL_SLEEP;
    end
  end

  // ----------------------------------------
  // interrupts: alarm, trip, pump change, sleep, wake
  // ----------------------------------------
  logic alarm_d_ff;
  logic [1:0] pump_d_ff;
  dps_sleep_t sl_d_ff;
  logic [4:0] ist_ff, imask_ff;
  wire logic [4:0] ev = {sl_d_ff == SL_SLEEP && sl_ff == SL_RUN,
    sl_d_ff == SL_RUN && sl_ff == SL_ENTRY, pump_d_ff != pump_on,
    fault_trip && !trip_d_ff, ot_alarm && !alarm_d_ff};
  wire logic [4:0] w1c = (reg_wr && reg_addr == `DPS_IRQ_STAT) ? reg_wdata[4:0] : 5'h00;
  // an event in the clear cycle survives, set wins
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_d_ff <= 1'b0;
      pump_d_ff <= 2'b00;
      sl_d_ff <= SL_RUN;
      ist_ff <= 5'h00;
      imask_ff <= 5'h00;
      irq <= 1'b0;
    end
    else
    begin
      alarm_d_ff <= ot_alarm;
      pump_d_ff <= pump_on;
      sl_d_ff <= sl_ff;
      ist_ff <= (ist_ff & ~w1c) | ev;
      if (reg_wr && reg_addr == `DPS_IRQ_MASK)
        imask_ff <= reg_wdata[4:0];
      irq <= |(((ist_ff & ~w1c) | ev) & imask_ff);
    end
  end

  // ----------------------------------------
  // register read port, data one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      if (reg_addr < 5'(`DPS_NCFG))
        reg_rdata <= cfg_ff[reg_addr];
      else if (reg_addr == `DPS_STATUS)
        reg_rdata <= {4'h0, resume_valid, resume_step, sl_ff, pump_on,
          fault_trip, ot_alarm, n_on_ff[1]};
      else if (reg_addr == `DPS_IRQ_STAT)
        reg_rdata <= {11'h000, ist_ff};
      else if (reg_addr == `DPS_IRQ_MASK)
        reg_rdata <= {11'h000, imask_ff};
      else
        reg_rdata <= 16'h0000;
    end
  end
endmodule : dps_supervisor

// ===== tb/dps_supervisor_checker.sv
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_supervisor_checker
  import dps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire dps_meas_t meas,
  input wire dps_run_t run,
  input wire logic hold_accel,
  input wire logic hold_decel,
  input wire logic lower_freq,
  input wire logic [1:0] pump_on,
  input wire logic sleep_freq_req,
  input wire logic sleep_stop,
  input wire logic ot_alarm,
  input wire logic fault_trip,
  input wire logic irq
);
  // one clock domain, so clock and disable are declared once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // stall requests
  // ----------------------------------------
  // a request may only follow the ramp phase seen one cycle before
  chk_accel_phase: assert property (hold_accel |-> $past(run.accel))
    else $error("accel hold outside ramp-up");
  chk_accel_quiet: assert property (run.accel && meas.current == 8'h00 |=> !hold_accel)
    else $error("accel hold with zero current");
  chk_decel_phase: assert property (hold_decel |-> $past(run.decel))
    else $error("decel hold outside ramp-down");
  chk_lower_phase: assert property (lower_freq |-> $past(run.at_speed))
    else $error("frequency lowered off speed");
  // ----------------------------------------
  // over-torque, pumps, sleep
  // ----------------------------------------
  // trip is latched; only a clear write may drop it
  chk_trip_latch: assert property (fault_trip && !(reg_wr && reg_addr == `DPS_FAULT_CLR
    && reg_wdata[0]) |=> fault_trip)
    else $error("trip dropped without clear");
  chk_trip_alarm: assert property ($rose(fault_trip) |-> ot_alarm)
    else $error("trip without preceding alarm");
  // duty handover must pass through both contacts open
  chk_pump_gap_a: assert property (pump_on == 2'b01 |=> pump_on != 2'b10)
    else $error("pump 1 to 2 without interlock");
  chk_pump_gap_b: assert property (pump_on == 2'b10 |=> pump_on != 2'b01)
    else $error("pump 2 to 1 without interlock");
  chk_sleep_order: assert property ($rose(sleep_stop) |-> $past(sleep_freq_req))
    else $error("sleep stop without sleep frequency");
  // ----------------------------------------
  // register port
  // ----------------------------------------
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_unmapped_rd: assert property (reg_rd && reg_addr > `DPS_FAULT_CLR |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cov_trip: cover property ($rose(fault_trip));
  cov_sleep: cover property ($rose(sleep_stop));
  cov_two_pumps: cover property (pump_on == 2'b11);
  cov_irq: cover property ($rose(irq));
endmodule : dps_supervisor_checker

bind dps_supervisor dps_supervisor_checker u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .meas(meas), .run(run), .hold_accel(hold_accel),
  .hold_decel(hold_decel), .lower_freq(lower_freq), .pump_on(pump_on),
  .sleep_freq_req(sleep_freq_req), .sleep_stop(sleep_stop), .ot_alarm(ot_alarm),
  .fault_trip(fault_trip), .irq(irq));

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dps_pkg::*;
  // a tick of 4 cycles makes one second 40 cycles
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  localparam logic [15:0] RST_VAL [18] = '{16'h0008, 16'h003c, 16'h0032, 16'h003c,
    16'h003c, 16'h005f, 16'h001e, 16'h0050, 16'h07d0, 16'h0014, 16'h0096, 16'h0000,
    16'h0000, 16'h0000, 16'h0064, 16'h1388, 16'h03e8, 16'h0320};
  logic clk, rst_n, reg_wr, reg_rd;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  dps_meas_t meas;
  dps_run_t run;
  logic [3:0] prog_step, resume_step;
  logic resume_valid, hold_accel, hold_decel, lower_freq, sleep_freq_req, sleep_stop;
  logic ot_alarm, fault_trip, irq;
  logic [1:0] pump_on;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  dps_supervisor #(.TICK_CYCLES(TICK)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas(meas), .run(run), .prog_step(prog_step), .resume_step(resume_step),
    .resume_valid(resume_valid), .hold_accel(hold_accel), .hold_decel(hold_decel),
    .lower_freq(lower_freq), .pump_on(pump_on), .sleep_freq_req(sleep_freq_req),
    .sleep_stop(sleep_stop), .ot_alarm(ot_alarm), .fault_trip(fault_trip), .irq(irq));

  // ----------------------------------------
  // clock, timeout and report
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // cuts a hang short; the longest wait is the pump rotation minute
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------
  // access and compare helpers
  // ----------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // strobe rises one edge after the last drop, so no signal is driven twice at one edge
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  function automatic logic [47:0] mk(input logic [7:0] c, input logic [15:0] v,
    input logic [15:0] f, input logic [7:0] fb);
    return {c, v, f, fb};
  endfunction : mk

  task apply(input logic [47:0] m, input logic [3:0] r, input int n);
    @(posedge clk);
    meas <= m;
    run <= r;
    repeat (n) @(posedge clk);
    #1;
  endtask : apply

  task stall(input logic [47:0] m, input logic [3:0] r, input logic [2:0] e);
    apply(m, r, 2);
    chk(16'({hold_accel, hold_decel, lower_freq}), 16'(e));
  endtask : stall

  // selector 5 means exactly one pump contact closed
  function automatic logic [1:0] sig(input int sel);
    case (sel)
      0: return {1'b0, ot_alarm};
      1: return {1'b0, fault_trip};
      2: return pump_on;
      3: return {1'b0, sleep_freq_req};
      4: return {1'b0, sleep_stop};
      default: return {1'b0, ^pump_on};
    endcase
  endfunction : sig

  task automatic wait_sig(input int sel, input logic [1:0] v, input int lim);
    for (int i = 0; i < lim && sig(sel) !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(16'(sig(sel)), 16'(v));
  endtask : wait_sig

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    meas = '0;
    run = '0;
    prog_step = 4'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, unmapped place, mask read-back
    for (int a = 0; a < 18; a++)
      rd(5'(a), RST_VAL[a]);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    wr(5'h14, 16'h001f);
    rd(5'h14, 16'h001f);
    wr(5'h14, 16'h0000);
    // stall requests: strictly above the level, zero level disables
    stall(mk(8'h97, 16'h0000, 16'h0000, 8'h00), 4'b1100, 3'b100);
    stall(mk(8'h96, 16'h0000, 16'h0000, 8'h00), 4'b1100, 3'b000);
    stall(mk(8'hc8, 16'h0000, 16'h0000, 8'h00), 4'b1001, 3'b000);
    wr(5'h0b, 16'h0078);
    stall(mk(8'h79, 16'h0000, 16'h0000, 8'h00), 4'b1001, 3'b001);
    stall(mk(8'h78, 16'h0000, 16'h0000, 8'h00), 4'b1001, 3'b000);
    stall(mk(8'h00, 16'h0321, 16'h0000, 8'h00), 4'b1010, 3'b010);
    stall(mk(8'h00, 16'h0320, 16'h0000, 8'h00), 4'b1010, 3'b000);
    wr(5'h0a, 16'h0000);
    stall(mk(8'hc8, 16'h0000, 16'h0000, 8'h00), 4'b1100, 3'b000);
    wr(5'h00, 16'h0000);
    stall(mk(8'h00, 16'h0400, 16'h0000, 8'h00), 4'b1010, 3'b000);
    wr(5'h0c, 16'h00e8);
    rd(5'h0c, 16'h00e8);
    stall(mk(8'he9, 16'h0000, 16'h0000, 8'h00), 4'b1010, 3'b010);
    // every over-torque mode, off and at speed; detect time 0.4 s
    wr(5'h0d, 16'h0064);
    wr(5'h0e, 16'h0004);
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
        wr(5'h15, 16'h0001);
        wr(5'h00, 16'h0008 | 16'(m << 4));
        apply(mk(8'h65, 16'h0000, 16'h0000, 8'h00), {3'b100, s[0]}, 40);
        chk(16'({ot_alarm, fault_trip}), 16'({m[1] | s[0], (m[1] | s[0]) & m[0]}));
      end
    end
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    wr(5'h15, 16'h0001);
    wr(5'h0d, 16'h0000);
    apply(mk(8'hff, 16'h0000, 16'h0000, 8'h00), 4'b1001, 40);
    chk(16'({ot_alarm, fault_trip}), 16'h0000);
    // alarm then trip, interrupt masked, raised, cleared
    wr(5'h0d, 16'h0064);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    wr(5'h13, 16'hffff);
    wr(5'h14, 16'h0002);
    apply(mk(8'h65, 16'h0000, 16'h0000, 8'h00), 4'b1000, 1);
    wait_sig(0, 2'b01, 40);
    chk(16'({fault_trip, irq}), 16'h0000);
    wait_sig(1, 2'b01, 40);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 4);
    chk(16'({fault_trip, irq}), 16'h0003);
    rd(5'h12, 16'h0004);
    rd(5'h13, 16'h0003);
    wr(5'h13, 16'h0003);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    chk(16'(irq), 16'h0000);
    wr(5'h15, 16'h0001);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    chk(16'(fault_trip), 16'h0000);
    // an interrupted overload restarts the duration count
    apply(mk(8'h65, 16'h0000, 16'h0000, 8'h00), 4'b1000, 8);
    apply(mk(8'h64, 16'h0000, 16'h0000, 8'h00), 4'b1000, 4);
    apply(mk(8'h65, 16'h0000, 16'h0000, 8'h00), 4'b1000, 8);
    chk(16'(ot_alarm), 16'h0000);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    // two pumps: staging up, rotation with interlock, staging down
    wr(5'h00, 16'h000c);
    wr(5'h03, 16'h0001);
    wr(5'h04, 16'h0001);
    wr(5'h01, 16'h0001);
    wr(5'h02, 16'h0002);
    apply(mk(8'h00, 16'h0000, 16'h1388, 8'h00), 4'b1001, 1);
    wait_sig(2, 2'b01, 60);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h00), 4'b1001, 2300);
    chk(16'(pump_on), 16'h0001);
    wait_sig(2, 2'b00, 200);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h00), 4'b1001, 4);
    chk(16'(pump_on), 16'h0000);
    wait_sig(2, 2'b10, 20);
    apply(mk(8'h00, 16'h0000, 16'h1388, 8'h00), 4'b1001, 1);
    wait_sig(2, 2'b11, 60);
    apply(mk(8'h00, 16'h0000, 16'h0100, 8'h00), 4'b1001, 1);
    wait_sig(5, 2'b01, 60);
    wait_sig(2, 2'b00, 60);
    // sleep: just below the level, at the level, then wake
    wr(5'h06, 16'h0001);
    wr(5'h09, 16'h0001);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h5e), 4'b1001, 60);
    chk(16'(sleep_freq_req), 16'h0000);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h5f), 4'b1001, 1);
    wait_sig(3, 2'b01, 60);
    chk(16'(sleep_stop), 16'h0000);
    wait_sig(4, 2'b01, 60);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h50), 4'b1001, 20);
    chk(16'(sleep_stop), 16'h0001);
    apply(mk(8'h00, 16'h0000, 16'h0800, 8'h4f), 4'b1001, 1);
    wait_sig(4, 2'b00, 10);
    // program step kept on stop only while memory is on
    wr(5'h00, 16'h0001);
    @(posedge clk);
    prog_step <= 4'h5;
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b0000, 3);
    chk(16'({resume_valid, resume_step}), 16'h0015);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b1000, 2);
    wr(5'h00, 16'h0000);
    apply(mk(8'h00, 16'h0000, 16'h0000, 8'h00), 4'b0000, 3);
    chk(16'(resume_valid), 16'h0000);
    end_sim();
  end
endmodule : testbench
